//--- core/pdc_pkg.sv
package pdc_pkg;
    localparam int NCH = 2;
    localparam int CH_W = 1;
    localparam int NPER = 8;
    localparam int PID_W = 4;
    localparam int ADDR_W = 12;
    localparam int FIFO_DEPTH = 4;
    // Channel stride and window mask
    localparam logic [ADDR_W-1:0] CH_STRIDE = 12'h040;
    localparam logic [ADDR_W-1:0] CH_MASK = 12'h03f;
    // Register offsets inside a channel window, plus the global revision address outside every window
    localparam logic [5:0] OFS_MEM_PTR = 6'h00;
    localparam logic [5:0] OFS_PER_SEL = 6'h04;
    localparam logic [5:0] OFS_ITEM_CNT = 6'h08;
    localparam logic [5:0] OFS_PTR_RLD = 6'h0c;
    localparam logic [5:0] OFS_CNT_RLD = 6'h10;
    localparam logic [5:0] OFS_CMD = 6'h14;
    localparam logic [5:0] OFS_CFG = 6'h18;
    localparam logic [5:0] OFS_STATE = 6'h1c;
    localparam logic [5:0] OFS_IRQ_SET = 6'h20;
    localparam logic [5:0] OFS_IRQ_CLR = 6'h24;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h28;
    localparam logic [5:0] OFS_IRQ_FLAGS = 6'h2c;
    localparam logic [ADDR_W-1:0] OFS_REVISION = 12'h834;
    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [PID_W-1:0] RST_PER_SEL = 4'hf;
    localparam logic [31:0] RST_REVISION = 32'h0000_0123; // Arbitrary value
    // Field positions
    localparam int CMD_TEN = 0;
    localparam int CMD_TDIS = 1;
    localparam int CMD_ECLR = 8;
    localparam int CFG_SIZE_LO = 0;
    localparam int CFG_ETRIG = 2;
    localparam int CFG_RING = 3;
    localparam int ST_TEN = 0;
    localparam int IRQ_RCZ = 0;
    localparam int IRQ_TRC = 1;
    localparam int IRQ_TERR = 2;
    localparam int PID_DIR = 3;
    localparam int CNT_W = 16;
    // Peripheral holding registers
    localparam logic [31:0] PER_BASE = 32'h4000_0000;
    localparam logic [31:0] PER_STRIDE = 32'h0000_0400;
    // Transfer sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;

    typedef struct packed {
        logic [CH_W-1:0] chan;
        logic to_per;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] data;
    } pdc_item_t;
    localparam int ITEM_W = $bits(pdc_item_t);
endpackage : pdc_pkg

//--- core/pdc_fifo_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pdc_fifo_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : pdc_fifo_if
`default_nettype wire

//--- core/pdc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module pdc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    pdc_fifo_if.snk wr,
    pdc_fifo_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_q != '0);
    assign rd.data = mem_q[rp_q];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem_q[wp_q] <= wr.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : pdc_fifo
`default_nettype wire

//--- core/pdc_top.sv
// What this block does
// - Each channel decodes its registers in a 64-byte window at channel times stride.
// - Memory pointer holds the full address of the next memory access.
// - Item counter is 16 low bits and shows items still to move.
// - Writing peripheral id picks handshake line, direction and holding address.
// - Peripheral id sits in low 4 bits: line in bits 2:0, direction in bit 3.
// - Selector and revision reset to nonzero constants, all else to zero.
// - Pointer reload is a 32-bit read/write register at its own offset.
// - Pointer advances by one, two or four per item by transfer size.
// - Item counter decrements by one per item.
// - Nonzero write to counter or counter reload starts an enabled channel.
// - Counter reaching zero with nonzero reload copies both reloads in.
`timescale 1ns/100ps
`default_nettype none
module pdc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclken,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pdc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pdc_pkg::NPER-1:0] per_req,
    output logic [pdc_pkg::NPER-1:0] per_ack,
    output logic [2:0] per_rsel,
    input wire logic [31:0] per_rdata,
    input wire logic [pdc_pkg::NCH-1:0] per_event,
    output logic per_wvalid,
    output logic [31:0] per_waddr,
    output logic [31:0] per_wdata,
    output logic mem_valid,
    input wire logic mem_ready,
    input wire logic mem_err,
    output logic mem_write,
    output logic [1:0] mem_size,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata
);
    import pdc_pkg::*;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] size_step(input logic [1:0] sz);
        case (sz)
            SZ_BYTE: size_step = 32'h0000_0001;
            SZ_HALF: size_step = 32'h0000_0002;
            default: size_step = 32'h0000_0004;
        endcase
    endfunction : size_step

    // Bits above the item size read as zero
    function automatic logic [31:0] size_mask(input logic [1:0] sz, input logic [31:0] d);
        case (sz)
            SZ_BYTE: size_mask = {24'h00_0000, d[7:0]};
            SZ_HALF: size_mask = {16'h0000, d[15:0]};
            default: size_mask = d;
        endcase
    endfunction : size_mask

    function automatic logic [31:0] hold_addr(input logic [PID_W-1:0] peripheral_ident);
        hold_addr = PER_BASE + PER_STRIDE * {29'h0000_0000, peripheral_ident[2:0]};
    endfunction : hold_addr

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    logic [31:0] ptr_q [NCH];
    logic [PID_W-1:0] pid_q [NCH];
    logic [CNT_W-1:0] cnt_q [NCH];
    logic [31:0] ptr_rld_q [NCH];
    logic [CNT_W-1:0] cnt_rld_q [NCH];
    logic [1:0] size_q [NCH];
    logic etrig_q [NCH];
    logic ring_q [NCH];
    logic en_q [NCH];
    logic terr_q [NCH];
    logic evpend_q [NCH];
    logic [2:0] imask_q [NCH];
    logic [31:0] prdata_q;
    logic pslverr_q;

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    logic [5:0] ofs;
    logic [5:0] chn;
    logic in_ch;
    logic is_rev;
    logic wr_acc;
    logic setup;

    assign ofs = paddr[5:0] & CH_MASK[5:0];
    assign chn = paddr[11:6];
    assign in_ch = (chn < 6'(NCH)) && (ofs <= OFS_IRQ_FLAGS) && (paddr[1:0] == 2'h0);
    assign is_rev = (paddr == OFS_REVISION);
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && in_ch;
    // Zero wait state: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q && psel && penable;

    function automatic logic wr_hit(input int ch, input logic [5:0] o);
        wr_hit = wr_acc && (chn == 6'(ch)) && (ofs == o);
    endfunction : wr_hit

    // ---------------------------------------------------------------
    // Arbitration: lowest channel wins
    // ---------------------------------------------------------------
    logic [NCH-1:0] want;
    logic gnt_any;
    logic [CH_W-1:0] gnt_ch;
    logic [2:0] gnt_line;
    logic fifo_in_ready;
    pdc_fifo_if #(.WIDTH(ITEM_W)) q_in ();
    pdc_fifo_if #(.WIDTH(ITEM_W)) q_out ();
    pdc_item_t item;
    pdc_item_t head;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            want[c] = en_q[c] && !terr_q[c] && (cnt_q[c] != '0) && per_req[pid_q[c][2:0]]
                      && (!etrig_q[c] || evpend_q[c]);
        end
    end

    always_comb begin
        gnt_any = 1'b0;
        gnt_ch = '0;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (want[c]) begin
                gnt_any = 1'b1;
                gnt_ch = CH_W'(c);
            end
        end
    end

    assign fifo_in_ready = q_in.ready;
    assign gnt_line = pid_q[gnt_ch][2:0];
    assign per_rsel = gnt_line;

    always_comb begin
        per_ack = '0;
        if (gnt_any && fifo_in_ready && pclken) begin
            per_ack[gnt_line] = 1'b1;
        end
    end

    always_comb begin
        item.chan = gnt_ch;
        item.to_per = pid_q[gnt_ch][PID_DIR];
        item.size = size_q[gnt_ch];
        item.addr = ptr_q[gnt_ch];
        item.data = size_mask(size_q[gnt_ch], per_rdata);
    end

    assign q_in.valid = gnt_any;
    assign q_in.data = item;

    pdc_fifo #(.WIDTH(ITEM_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pclken),
        .wr(q_in),
        .rd(q_out)
    );

    // ---------------------------------------------------------------
    // Memory port
    // ---------------------------------------------------------------
    assign head = pdc_item_t'(q_out.data);
    assign mem_valid = q_out.valid;
    assign mem_write = !head.to_per;
    assign mem_size = head.size;
    assign mem_addr = head.addr;
    assign mem_wdata = head.data;
    // Items queued behind a failing one still retire
    assign q_out.ready = mem_ready;

    logic done;
    assign done = q_out.valid && mem_ready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_wvalid <= 1'b0;
            per_waddr <= RST_ZERO;
            per_wdata <= RST_ZERO;
        end else if (pclken) begin
            per_wvalid <= done && head.to_per && !mem_err;
            if (done && head.to_per) begin
                per_waddr <= hold_addr(pid_q[head.chan]);
                per_wdata <= size_mask(head.size, mem_rdata);
            end
        end
    end

    // ---------------------------------------------------------------
    // Channel pointers and counters
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NCH; c++) begin
                ptr_q[c] <= RST_ZERO;
                cnt_q[c] <= '0;
                ptr_rld_q[c] <= RST_ZERO;
                cnt_rld_q[c] <= '0;
            end
        end else if (pclken) begin
            for (int c = 0; c < NCH; c++) begin
                logic [31:0] p;
                logic [CNT_W-1:0] n;
                logic [31:0] pr;
                logic [CNT_W-1:0] nr;
                p = ptr_q[c];
                n = cnt_q[c];
                pr = ptr_rld_q[c];
                nr = cnt_rld_q[c];
                if (gnt_any && fifo_in_ready && gnt_ch == CH_W'(c)) begin
                    p = p + size_step(size_q[c]);
                    n = n - 1'b1;
                end
                if (wr_hit(c, OFS_MEM_PTR)) begin
                    p = pwdata;
                end
                if (wr_hit(c, OFS_ITEM_CNT)) begin
                    n = pwdata[CNT_W-1:0];
                end
                if (wr_hit(c, OFS_PTR_RLD)) begin
                    pr = pwdata;
                end
                if (wr_hit(c, OFS_CNT_RLD)) begin
                    nr = pwdata[CNT_W-1:0];
                end
                if (n == '0 && nr != '0) begin
                    p = pr;
                    n = nr;
                    if (!ring_q[c]) begin
                        pr = RST_ZERO;
                        nr = '0;
                    end
                end
                ptr_q[c] <= p;
                cnt_q[c] <= n;
                ptr_rld_q[c] <= pr;
                cnt_rld_q[c] <= nr;
            end
        end
    end

    // ---------------------------------------------------------------
    // Selector, mode, enable, error, events
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NCH; c++) begin
                pid_q[c] <= RST_PER_SEL;
                size_q[c] <= SZ_BYTE;
                etrig_q[c] <= 1'b0;
                ring_q[c] <= 1'b0;
                imask_q[c] <= 3'h0;
            end
        end else if (pclken) begin
            for (int c = 0; c < NCH; c++) begin
                if (wr_hit(c, OFS_PER_SEL)) begin
                    pid_q[c] <= pwdata[PID_W-1:0];
                end
                if (wr_hit(c, OFS_CFG)) begin
                    size_q[c] <= pwdata[CFG_SIZE_LO +: 2];
                    etrig_q[c] <= pwdata[CFG_ETRIG];
                    ring_q[c] <= pwdata[CFG_RING];
                end
                if (wr_hit(c, OFS_IRQ_SET)) begin
                    imask_q[c] <= imask_q[c] | pwdata[2:0];
                end
                if (wr_hit(c, OFS_IRQ_CLR)) begin
                    imask_q[c] <= imask_q[c] & ~pwdata[2:0];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NCH; c++) begin
                en_q[c] <= 1'b0;
                terr_q[c] <= 1'b0;
                evpend_q[c] <= 1'b0;
            end
        end else if (pclken) begin
            for (int c = 0; c < NCH; c++) begin
                logic granted;
                granted = gnt_any && fifo_in_ready && gnt_ch == CH_W'(c);
                if (wr_hit(c, OFS_CMD) && pwdata[CMD_TEN]) begin
                    en_q[c] <= 1'b1;
                end
                // Disable wins if both bits are written together
                if (wr_hit(c, OFS_CMD) && pwdata[CMD_TDIS]) begin
                    en_q[c] <= 1'b0;
                end
                // Error set wins over a clear in the same cycle
                if (wr_hit(c, OFS_CMD) && pwdata[CMD_ECLR]) begin
                    terr_q[c] <= 1'b0;
                end
                if (done && mem_err && head.chan == CH_W'(c)) begin
                    terr_q[c] <= 1'b1;
                end
                // One event lets one item through
                if (granted && etrig_q[c]) begin
                    evpend_q[c] <= 1'b0;
                end
                if (per_event[c]) begin
                    evpend_q[c] <= 1'b1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    logic [31:0] rd_next;

    always_comb begin
        logic [31:0] r;
        int c;
        r = RST_ZERO;
        c = int'(chn);
        if (is_rev) begin
            r = RST_REVISION;
        end else if (in_ch) begin
            case (ofs)
                OFS_MEM_PTR: r = ptr_q[c];
                OFS_PER_SEL: r = {28'h000_0000, pid_q[c]};
                OFS_ITEM_CNT: r = {16'h0000, cnt_q[c]};
                OFS_PTR_RLD: r = ptr_rld_q[c];
                OFS_CNT_RLD: r = {16'h0000, cnt_rld_q[c]};
                OFS_CFG: r = {28'h000_0000, ring_q[c], etrig_q[c], size_q[c]};
                OFS_STATE: r = {31'h0000_0000, en_q[c]};
                OFS_IRQ_MASK: r = {29'h0000_0000, imask_q[c]};
                // Count flags live only while enabled, so they read zero from reset
                OFS_IRQ_FLAGS: r = {29'h0000_0000, terr_q[c],
                                    en_q[c] && (cnt_q[c] == '0) && (cnt_rld_q[c] == '0),
                                    en_q[c] && (cnt_rld_q[c] == '0)};
                default: r = RST_ZERO;
            endcase
        end
        rd_next = r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= RST_ZERO;
            pslverr_q <= 1'b0;
        end else if (pclken && setup) begin
            prdata_q <= pwrite ? RST_ZERO : rd_next;
            pslverr_q <= !(in_ch || (is_rev && !pwrite));
        end
    end
endmodule : pdc_top
`default_nettype wire

//--- verif/pdc_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module pdc_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pwrite,
    input wire logic [pdc_pkg::NPER-1:0] per_req,
    input wire logic [pdc_pkg::NPER-1:0] per_ack,
    input wire logic [2:0] per_rsel,
    input wire logic per_wvalid,
    input wire logic [31:0] per_waddr,
    input wire logic mem_valid,
    input wire logic mem_ready,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr
);
    import pdc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    property p_ready; s_setup ##1 s_access |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("access without ready");
    property p_err_phase; !(psel && penable) |-> !pslverr; endproperty
    a_err_phase: assert property (p_err_phase) else $error("error outside access");
    property p_err_zero; s_access and (pslverr && !pwrite) |-> prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
    // Read data stays put between setups, so a late sample is still right
    property p_rd_hold; !(psel && !penable) |=> $stable(prdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_ack_one; $onehot0(per_ack); endproperty
    a_ack_one: assert property (p_ack_one) else $error("several acks");
    property p_ack_line; |per_ack |-> per_ack == (8'h01 << per_rsel) && (per_ack & ~per_req) == 8'h0;
    endproperty
    a_ack_line: assert property (p_ack_line) else $error("ack on wrong line");
    property p_wv; per_wvalid |-> $past(mem_valid && mem_ready && !mem_write); endproperty
    a_wv: assert property (p_wv) else $error("holding write without read");
    property p_hold_addr; per_wvalid |-> per_waddr[31:13] == 19'h20000 && per_waddr[9:0] == 10'h0;
    endproperty
    a_hold_addr: assert property (p_hold_addr) else $error("bad holding address");
    property p_head; mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) && $stable(mem_write);
    endproperty
    a_head: assert property (p_head) else $error("memory request dropped");
endmodule : pdc_chk
bind pdc_top pdc_chk u_pdc_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
    .pwrite, .per_req, .per_ack, .per_rsel, .per_wvalid, .per_waddr, .mem_valid, .mem_ready,
    .mem_write, .mem_addr);
`default_nettype wire

//--- verif/pdc_per_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Peripherals and memory on the far side
// ----------------------------------------
module pdc_per_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic [7:0] req_en,
    input wire logic [7:0] per_ack,
    input wire logic [2:0] per_rsel,
    input wire logic mem_valid,
    input wire logic [31:0] mem_addr,
    output logic [7:0] per_req,
    output logic [31:0] per_rdata,
    output logic mem_ready,
    output logic [31:0] mem_rdata
);
    logic [1:0] cnt_q;
    logic [31:0] pat;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 2'h0;
            per_req <= 8'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            per_req <= req_en;
        end
    end
    // Slow memory answers one cycle in four so the queue fills
    assign mem_ready = mem_valid && (!slow || cnt_q == 2'h3);
    assign pat = {29'h091a2b3, per_rsel};
    // Data not being taken shows the inverse, never a stale copy
    assign per_rdata = (|per_ack) ? pat : ~pat;
    assign mem_rdata = mem_ready ? (mem_addr ^ 32'h5a5a_0000) : ~(mem_addr ^ 32'h5a5a_0000);
endmodule : pdc_per_model
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import pdc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, per_wvalid, slow;
    logic mem_valid, mem_ready, mem_write;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, per_rdata, per_waddr, per_wdata, mem_addr, mem_wdata, mem_rdata;
    logic [7:0] per_req, per_ack, req_en;
    logic [2:0] per_rsel;
    logic [1:0] mem_size;
    int fails, n_checks;
    logic [31:0] mrq[$];
    logic [65:0] mwq[$];
    logic [63:0] pq[$];
    localparam logic [5:0] RO [9] = '{OFS_MEM_PTR, OFS_PER_SEL, OFS_ITEM_CNT, OFS_PTR_RLD,
        OFS_CNT_RLD, OFS_CFG, OFS_STATE, OFS_IRQ_MASK, OFS_IRQ_FLAGS};
    localparam logic [5:0] WO [6] = '{OFS_MEM_PTR, OFS_PTR_RLD, OFS_ITEM_CNT, OFS_CNT_RLD,
        OFS_PER_SEL, OFS_CFG};
    localparam logic [31:0] WM [6] = '{32'hffff_ffff, 32'hffff_ffff, 32'h0000_ffff,
        32'h0000_ffff, 32'h0000_000f, 32'h0000_000f};
    pdc_top u_pdc_top (.pclk, .presetn, .pclken(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .per_req, .per_ack, .per_rsel, .per_rdata,
        .per_event(2'h0), .per_wvalid, .per_waddr, .per_wdata, .mem_valid, .mem_ready,
        .mem_err(1'b0), .mem_write, .mem_size, .mem_addr, .mem_wdata, .mem_rdata);
    pdc_per_model u_pdc_per_model (.pclk, .presetn, .slow, .req_en, .per_ack, .per_rsel,
        .mem_valid, .mem_addr, .per_req, .per_rdata, .mem_ready, .mem_rdata);
    always #4 pclk = ~pclk;
    // ----------------------------------------
    // Monitor and helpers
    // ----------------------------------------
    always @(posedge pclk) begin
        if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
            if (mem_write) mwq.push_back({mem_size, mem_addr, mem_wdata});
            else mrq.push_back(mem_addr);
        end
        if (per_wvalid === 1'b1) pq.push_back({per_waddr, per_wdata});
    end
    task conclude;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : check
    function automatic logic [11:0] ra(input int ch, input logic [5:0] o);
        return (ch != 0 ? CH_STRIDE : 12'h0) | {6'h0, o};
    endfunction : ra
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n == 16) begin
            fails++;
            conclude();
        end
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(nm, exp, r);
    endtask : rdc
    // Bounded wait for the monitor to log n transfers
    task wait_q(input int n);
        int i;
        for (i = 0; i < 2000 && mwq.size() + mrq.size() + pq.size() < n; i++) @(posedge pclk);
        if (i == 2000) begin
            fails++;
            conclude();
        end
    endtask : wait_q
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        for (int c = 0; c < 2; c++)
            for (int i = 0; i < 9; i++)
                rdc("reset", ra(c, RO[i]), i == 1 ? {28'h0, RST_PER_SEL} : RST_ZERO);
        rdc("revision", OFS_REVISION, RST_REVISION);
        $display("test reset done");
    endtask : t_reset
    task t_rw;
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 6; i++) begin
            wr(ra(1, WO[i]), 32'hffff_ffff);
            rdc("field", ra(1, WO[i]), WM[i]);
        end
        rdc("ch0 untouched", ra(0, OFS_MEM_PTR), 32'h0);
        wr(ra(1, OFS_CNT_RLD), 32'h0);
        wr(ra(1, OFS_ITEM_CNT), 32'h0);
        apb(1'b0, 12'h030, 32'h0, r, e);
        check("hole err", 32'h1, {31'h0, e});
        check("hole data", 32'h0, r);
        apb(1'b1, OFS_REVISION, 32'h0, r, e);
        check("rev err", 32'h1, {31'h0, e});
        rdc("rev kept", OFS_REVISION, RST_REVISION);
        $display("test rw done");
    endtask : t_rw
    task t_p2m;
        mwq = {};
        wr(OFS_PER_SEL, 32'h2);
        wr(OFS_CFG, {30'h0, SZ_HALF});
        wr(OFS_MEM_PTR, 32'h2000_0000);
        req_en <= 8'h04;
        wr(OFS_CMD, 32'h1 << CMD_TEN);
        wr(OFS_ITEM_CNT, 32'h3);
        wait_q(3);
        req_en <= 8'h00;
        for (int i = 0; i < 3; i++) begin
            check("wr addr", 32'h2000_0000 + 2 * i, mwq[i][63:32]);
            // Line 2 pattern of the partner, cut to a halfword
            check("wr data", 32'h0000_159a, mwq[i][31:0]);
            check("wr size", {30'h0, SZ_HALF}, {30'h0, mwq[i][65:64]});
        end
        rdc("ptr", OFS_MEM_PTR, 32'h2000_0006);
        rdc("cnt", OFS_ITEM_CNT, 32'h0);
        $display("test p2m done");
    endtask : t_p2m
    task t_m2p;
        logic [31:0] a;
        mwq = {};
        mrq = {};
        pq = {};
        slow <= 1'b1;
        wr(OFS_PER_SEL, 32'hd);
        wr(OFS_CFG, {30'h0, SZ_WORD});
        wr(OFS_MEM_PTR, 32'h2000_0100);
        wr(OFS_ITEM_CNT, 32'h4);
        wr(OFS_PTR_RLD, 32'h2000_0200);
        wr(OFS_CNT_RLD, 32'h2);
        req_en <= 8'h20;
        wait_q(12);
        req_en <= 8'h00;
        slow <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            a = i < 4 ? 32'h2000_0100 + 4 * i : 32'h2000_01f0 + 4 * i;
            check("rd addr", a, mrq[i]);
            check("hold addr", 32'h4000_1400, pq[i][63:32]);
            check("hold data", a ^ 32'h5a5a_0000, pq[i][31:0]);
        end
        rdc("ptr", OFS_MEM_PTR, 32'h2000_0208);
        rdc("rld cleared", OFS_CNT_RLD, 32'h0);
        rdc("cnt", OFS_ITEM_CNT, 32'h0);
        $display("test m2p done");
    endtask : t_m2p
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        slow = 1'b0;
        req_en = 8'h0;
        fails = 0;
        n_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rw();
        t_p2m();
        t_m2p();
        conclude();
    end
endmodule : testbench
`default_nettype wire
